//--- src/mspi_pkg.sv
// Package for the master-only SPI mode of the serial port
package mspi_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CTRL   = 3'h1;
    localparam logic [2:0] ADDR_MODE   = 3'h2;
    localparam logic [2:0] ADDR_DATA   = 3'h3;
    localparam logic [2:0] ADDR_BAUD_L = 3'h4;
    localparam logic [2:0] ADDR_BAUD_H = 3'h5;
    // Status register bit positions
    localparam int RXC_BIT  = 7;
    localparam int TXC_BIT  = 6;
    localparam int UDRE_BIT = 5;
    // Control register bit positions
    localparam int RXCIE_BIT = 7;
    localparam int TXCIE_BIT = 6;
    localparam int BUFFER_EMPTY_IRQ_ENABLE_BIT = 5;
    localparam int RXEN_BIT  = 4;
    localparam int TXEN_BIT  = 3;
    // Mode register bit positions
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int ORDER_BIT   = 2;
    localparam int PHASE_BIT   = 1;
    localparam int POL_BIT     = 0;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h06;
    localparam logic [7:0] MODE_RESET = 8'h06;
    localparam logic [11:0] BAUD_RESET = 12'h000;
    localparam int FRAME_BITS = 8;
    // Operating modes
    typedef enum logic [1:0] {
        MODE_ASYNC = 2'b00,
        MODE_SYNC  = 2'b01,
        MODE_RSVD  = 2'b10,
        MODE_MSPI  = 2'b11
    } op_mode_t;
    // Interrupt request bundle
    typedef struct packed {
        logic rx_done;
        logic tx_done;
        logic buf_empty;
    } irq_t;
endpackage : mspi_pkg

//--- src/mspi_master.sv
// Serial port operated as a master-only SPI engine
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module mspi_master #(
    parameter int BAUD_W = 12          // Width of the baud divider
) (
    input  wire logic          I_CLK,      // System clock, 10 MHz
    input  wire logic          I_RST_N,    // Synchronous reset, active low
    input  wire logic [2:0]    I_ADDR,     // Register index
    input  wire logic [7:0]    I_WDATA,    // Write data
    input  wire logic          I_WR,       // Write strobe
    input  wire logic          I_RD,       // Read strobe
    output logic [7:0]         O_RDATA,    // Read data, cycle after strobe
    input  wire logic          I_GIE,      // Processor global interrupt enable
    input  wire logic          I_TXC_ACK,  // Transmit-complete interrupt serviced
    output mspi_pkg::irq_t     O_IRQ,      // Interrupt requests
    output logic               O_SCK,      // Serial clock pin
    output logic               O_SCK_OE,   // Serial clock drive enable
    output logic               O_MOSI,     // Serial output pin
    output logic               O_MOSI_OE,  // Serial output pin override
    input  wire logic          I_MISO,     // Serial input pin
    output logic               O_MISO_OWN  // Receiver owns the input pin
);
    import mspi_pkg::*;

    // Control and configuration registers
    logic [7:0]        ctrl_ff;
    logic [7:0]        mode_ff;
    logic [BAUD_W-1:0] baud_ff;
    logic              tx_en_ff;
    // Transmit buffer and shifter
    logic [7:0]        txbuf_ff;
    logic              txbuf_full_ff;
    logic [7:0]        shift_ff;
    logic              busy_ff;
    logic [3:0]        edge_cnt_ff;
    logic [BAUD_W-1:0] div_ff;
    logic              sck_ff;
    logic              mosi_ff;
    logic              txc_ff;
    // Receive buffer
    logic [7:0]        rxbuf_ff;
    logic              rxc_ff;
    logic [7:0]        rdata_ff;

    // Register decode
    wire wr_status = I_WR && (I_ADDR == ADDR_STATUS);
    wire wr_ctrl   = I_WR && (I_ADDR == ADDR_CTRL);
    wire wr_mode   = I_WR && (I_ADDR == ADDR_MODE);
    wire wr_data   = I_WR && (I_ADDR == ADDR_DATA);
    wire wr_baud_l = I_WR && (I_ADDR == ADDR_BAUD_L);
    wire wr_baud_h = I_WR && (I_ADDR == ADDR_BAUD_H);
    wire rd_data   = I_RD && (I_ADDR == ADDR_DATA);

    // Mode fields
    wire op_mode_t op_mode = op_mode_t'(mode_ff[MODE_HI_BIT:MODE_LO_BIT]);
    wire mspi_on   = (op_mode == MODE_MSPI);
    wire lsb_first = mode_ff[ORDER_BIT];
    wire cpha      = mode_ff[PHASE_BIT];
    wire cpol      = mode_ff[POL_BIT];
    wire rx_en     = ctrl_ff[RXEN_BIT];

    // Only the transmitter makes the clock, so receive-only never shifts
    wire can_start = mspi_on && tx_en_ff && txbuf_full_ff && !busy_ff;
    wire udre      = !txbuf_full_ff;
    // Baud tick: one half period of the serial clock per divider wrap
    wire half_tick = busy_ff && (div_ff == '0);
    wire last_edge = half_tick && (edge_cnt_ff == 4'(2*FRAME_BITS-1));
    // Leading edges are even counts; sample on leading for phase 0
    wire is_lead   = !edge_cnt_ff[0];
    wire sample_e  = half_tick && (is_lead ^ cpha);
    wire setup_e   = half_tick && !(is_lead ^ cpha) && (edge_cnt_ff != '0);
    wire out_bit   = lsb_first ? shift_ff[0] : shift_ff[7];
    wire in_bit    = I_MISO;

    // Status read: error bits and reserved bits read as zero
    wire [7:0] status_rd = {rxc_ff, txc_ff, udre, 5'h00};
    wire [7:0] ctrl_rd   = {ctrl_ff[7:4], tx_en_ff, 3'h0} | (ctrl_ff & 8'h07);
    wire [7:0] mode_rd   = mode_ff;
    wire [7:0] rd_mux    = (I_ADDR == ADDR_STATUS) ? status_rd :
                           (I_ADDR == ADDR_CTRL)   ? ctrl_rd   :
                           (I_ADDR == ADDR_MODE)   ? mode_rd   :
                           (I_ADDR == ADDR_DATA)   ? rxbuf_ff  :
                           (I_ADDR == ADDR_BAUD_L) ? 8'(baud_ff) :
                           (I_ADDR == ADDR_BAUD_H) ? 8'(baud_ff >> 8) : 8'h00;

    // Control register; reserved low bits keep their reset pattern
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= {I_WDATA[7:3], ctrl_ff[2:0]};
        end
    end

    // Mode, order, phase and polarity all land in one write
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            mode_ff <= MODE_RESET;
        end else if (wr_mode) begin
            mode_ff <= {I_WDATA[7:6], 3'h0, I_WDATA[2:0]};
        end
    end

    // Baud divider, split across two byte registers
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            baud_ff <= BAUD_W'(BAUD_RESET);
        end else if (wr_baud_l) begin
            baud_ff <= BAUD_W'({baud_ff[BAUD_W-1:8], I_WDATA});
        end else if (wr_baud_h) begin
            baud_ff <= BAUD_W'({I_WDATA, baud_ff[7:0]});
        end
    end

    // Effective transmitter enable: a disable waits for drained path
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            tx_en_ff <= 1'b0;
        end else if (ctrl_ff[TXEN_BIT]) begin
            tx_en_ff <= 1'b1;
        end else if (!busy_ff && !txbuf_full_ff) begin
            tx_en_ff <= 1'b0;
        end
    end

    // Transmit buffer: second level in front of the shifter
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            txbuf_ff      <= 8'h00;
            txbuf_full_ff <= 1'b0;
        end else if (wr_data && udre) begin
            txbuf_ff      <= I_WDATA;
            txbuf_full_ff <= 1'b1;
        end else if (can_start) begin
            txbuf_full_ff <= 1'b0;
        end
    end

    // Baud divider counter, restarted at each frame start
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || can_start || div_ff == '0) begin
            div_ff <= baud_ff;
        end else begin
            div_ff <= div_ff - 1'b1;
        end
    end

    // Shifter, clock and data output sequencing
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            busy_ff     <= 1'b0;
            edge_cnt_ff <= 4'h0;
            shift_ff    <= 8'h00;
            sck_ff      <= 1'b0;
            mosi_ff     <= 1'b1;
        end else if (can_start) begin
            busy_ff     <= 1'b1;
            edge_cnt_ff <= 4'h0;
            shift_ff    <= txbuf_ff;
            sck_ff      <= cpol;
            mosi_ff     <= cpha ? 1'b1 : (lsb_first ? txbuf_ff[0] : txbuf_ff[7]);
        end else if (half_tick) begin
            sck_ff      <= ~sck_ff;
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
            if (setup_e || (cpha && is_lead)) begin
                mosi_ff <= out_bit;
            end
            if (sample_e) begin
                shift_ff <= lsb_first ? {in_bit, shift_ff[7:1]}
                                      : {shift_ff[6:0], in_bit};
            end
            if (last_edge) begin
                busy_ff <= 1'b0;
            end
        end else if (!busy_ff) begin
            sck_ff  <= cpol;
            mosi_ff <= 1'b1;
        end
    end

    // Transmit complete: set wins over a same-cycle clear
    wire frame_end = last_edge && !txbuf_full_ff && !(wr_data && udre);
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            txc_ff <= 1'b0;
        end else if (frame_end) begin
            txc_ff <= 1'b1;
        end else if (I_TXC_ACK || (wr_status && I_WDATA[TXC_BIT])) begin
            txc_ff <= 1'b0;
        end
    end

    // Receive buffer; phase 0 took its last sample one edge before frame end
    wire [7:0] rx_shift = lsb_first ? {in_bit, shift_ff[7:1]} : {shift_ff[6:0], in_bit};
    wire [7:0] rx_word  = cpha ? rx_shift : shift_ff;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || !rx_en) begin
            rxc_ff   <= 1'b0;
            rxbuf_ff <= 8'h00;
        end else if (last_edge && (!rxc_ff || rd_data)) begin
            rxc_ff   <= 1'b1;
            rxbuf_ff <= rx_word;
        end else if (rd_data) begin
            rxc_ff   <= 1'b0;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || !I_RD) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= rd_mux;
        end
    end

    // Interrupt requests gated by enables and the global enable
    assign O_IRQ.rx_done   = ctrl_ff[RXCIE_BIT] && I_GIE && rxc_ff;
    assign O_IRQ.tx_done   = ctrl_ff[TXCIE_BIT] && I_GIE && txc_ff;
    assign O_IRQ.buf_empty = ctrl_ff[BUFFER_EMPTY_IRQ_ENABLE_BIT] && I_GIE && udre;

    // Pins; no slave select exists, master drives clock only in master SPI mode
    assign O_RDATA    = rdata_ff;
    assign O_SCK      = sck_ff;
    assign O_SCK_OE   = mspi_on;
    assign O_MOSI     = mosi_ff;
    assign O_MOSI_OE  = tx_en_ff;
    assign O_MISO_OWN = rx_en;

    // Checks: frame start and frame end are built from named steps
    sequence frame_go_s;
        can_start;
    endsequence
    sequence buf_taken_s;
        ##1 !txbuf_full_ff;
    endsequence
    sequence frame_last_s;
        last_edge;
    endsequence
    sequence shift_idle_s;
        ##1 !busy_ff;
    endsequence

    // Receive flag and receive buffer
    rx_flag_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !rx_en |=> !rxc_ff)
        else $error("receive flag survived disable");
    rx_set_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        last_edge && rx_en && !rxc_ff |=> rxc_ff)
        else $error("receive flag not set at frame end");
    rx_clear_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        rd_data && !last_edge && rx_en |=> !rxc_ff)
        else $error("receive flag not cleared by read");
    rx_keep_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        last_edge && rx_en && rxc_ff && !rd_data |=> $stable(rxbuf_ff))
        else $error("older receive byte overwritten");

    // Transmit complete and buffer empty flags, zero status bits
    txc_set_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        frame_end |=> txc_ff)
        else $error("transmit complete not set");
    txc_clear_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        I_TXC_ACK && !frame_end |=> !txc_ff)
        else $error("transmit complete not cleared");
    udre_reset_a: assert property (
        @(posedge I_CLK)
        !I_RST_N |=> udre)
        else $error("buffer empty low after reset");
    udre_fill_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        wr_data && udre |=> !udre)
        else $error("buffer empty after accepted write");
    status_zero_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        $past(I_RD) && $past(I_ADDR) == ADDR_STATUS |-> O_RDATA[4:0] == 5'h00)
        else $error("error bits not zero");

    // Interrupt gating
    rx_irq_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        O_IRQ.rx_done |-> rxc_ff && I_GIE)
        else $error("stray receive irq");
    tx_irq_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        O_IRQ.tx_done |-> txc_ff && I_GIE)
        else $error("stray transmit irq");
    empty_irq_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        O_IRQ.buf_empty |-> udre && I_GIE)
        else $error("stray empty irq");
    irq_gate_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !I_GIE |-> O_IRQ == 3'h0)
        else $error("irq without global enable");

    // Enables, mode and reserved bits
    rx_only_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !tx_en_ff |=> !busy_ff || $past(busy_ff))
        else $error("receive-only transfer");
    mode_gate_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !mspi_on && !busy_ff |=> !busy_ff)
        else $error("transfer outside master mode");
    tx_hold_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        busy_ff && !ctrl_ff[TXEN_BIT] |=> tx_en_ff)
        else $error("early disable");
    tx_drain_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !ctrl_ff[TXEN_BIT] && tx_en_ff && (busy_ff || txbuf_full_ff) |=> tx_en_ff)
        else $error("disable with data pending");
    tx_off_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !ctrl_ff[TXEN_BIT] && !busy_ff && !txbuf_full_ff |=> !O_MOSI_OE)
        else $error("output pin kept after disable");
    ctrl_rsvd_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        wr_ctrl |=> $stable(ctrl_ff[2:0]))
        else $error("read-only control bits written");
    mode_rsvd_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        wr_mode |=> mode_ff[5:3] == 3'h0)
        else $error("reserved mode bits set");

    // Frame sequencing and serial clock
    buf_start_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        frame_go_s |-> buf_taken_s)
        else $error("buffer not moved");
    busy_start_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        frame_go_s |=> busy_ff)
        else $error("frame did not start");
    frame_stop_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        frame_last_s |-> shift_idle_s)
        else $error("frame ran past sixteen edges");
    mosi_idle_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !busy_ff && !can_start |=> O_MOSI)
        else $error("output not idle high");
    sck_idle_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        !busy_ff && !$past(busy_ff) |=> O_SCK == $past(cpol))
        else $error("clock not idle");
    sck_hold_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        busy_ff && !half_tick |=> $stable(O_SCK))
        else $error("clock moved between ticks");
    sck_toggle_a: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        half_tick |=> O_SCK != $past(O_SCK))
        else $error("clock missed a tick");
endmodule : mspi_master
`default_nettype wire

//--- sim/spi_slave_model.sv
// Behavioural slave on the serial bus of the master SPI port
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model (
    input  wire logic       i_clk,      // System clock
    input  wire logic       i_rst_n,    // Reset, active low
    input  wire logic       i_sck,      // Serial clock from master
    input  wire logic       i_mosi,     // Data from master
    input  wire logic       i_cpol,     // Clock idle level
    input  wire logic       i_cpha,     // Sample on trailing edge
    input  wire logic       i_lsb,      // Least significant bit first
    input  wire logic [7:0] i_reply,    // Reply base, plus frame count
    output logic            o_miso,     // Data to master
    output logic [7:0]      o_rx_byte,  // Last byte taken from master
    output logic [7:0]      o_frames    // Completed frames
);
    logic       sck_ff;
    logic [3:0] edges_ff;
    logic [5:0] idle_ff;
    logic [7:0] shift_ff;
    logic       junk_ff;
    logic [7:0] reply;
    logic [4:0] pos;
    logic [7:0] nxt_shift;
    logic       edge_seen;
    logic       sample_edge;
    // Rising edge samples when polarity equals phase
    assign edge_seen   = (i_sck != sck_ff);
    assign sample_edge = edge_seen && ((i_sck == 1'b1) == (i_cpol == i_cpha));
    assign nxt_shift   = !sample_edge ? shift_ff :
                         (i_lsb ? {i_mosi, shift_ff[7:1]} : {shift_ff[6:0], i_mosi});
    // Phase one presents its first bit only at the leading edge
    assign reply  = i_reply + o_frames;
    assign pos    = {1'b0, edges_ff} - {4'h0, i_cpha};
    // Outside the bit window the line toggles, never holding the last bit
    assign o_miso = pos[4] ? junk_ff : (i_lsb ? reply[pos[3:1]] : reply[3'd7 - pos[3:1]]);
    // Edge counting; a long quiet clock resynchronises the bit count
    always_ff @(posedge i_clk) begin
        sck_ff  <= i_sck;
        junk_ff <= ~junk_ff;
        if (!i_rst_n) begin
            {edges_ff, idle_ff, shift_ff, junk_ff, o_rx_byte, o_frames} <= '0;
        end else if (edge_seen) begin
            idle_ff  <= 6'h0;
            edges_ff <= edges_ff + 4'h1;
            shift_ff <= nxt_shift;
            if (edges_ff == 4'hf) begin
                o_rx_byte <= nxt_shift;
                o_frames  <= o_frames + 8'h1;
            end
        end else if (idle_ff == 6'h20) begin
            edges_ff <= 4'h0;
        end else begin
            idle_ff <= idle_ff + 6'h1;
        end
    end
endmodule : spi_slave_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the master-only SPI serial port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import mspi_pkg::*;
    typedef struct packed {
        logic [2:0] fmt;     // Order, phase, polarity
        logic [7:0] tx;      // Byte sent by the master
        logic [7:0] reply;   // Reply base of the slave
        logic [7:0] exp_rd;  // Byte the master should receive
    } row_t;
    localparam int LIMIT = 20000;  // Run needs under two thousand cycles
    logic       clk, rst_n, wr_stb, rd_stb, gie, ack, sck, sck_oe, mosi, mosi_oe, miso, miso_own;
    logic       cpol, cpha, lsb;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, reply, rx_byte, frames, st;
    irq_t       irq;
    int         num_errors = 0, n_compared = 0, cycles = 0;
    // Every format once; reply grows by one per frame in the slave
    row_t       rows [8] = '{'{3'h0, 8'ha5, 8'h3c, 8'h3c}, '{3'h1, 8'h5a, 8'hc3, 8'hc4},
                             '{3'h2, 8'h81, 8'h0f, 8'h11}, '{3'h3, 8'h7e, 8'hf0, 8'hf3},
                             '{3'h4, 8'h01, 8'h96, 8'h9a}, '{3'h5, 8'h80, 8'h69, 8'h6e},
                             '{3'h6, 8'hc8, 8'h12, 8'h18}, '{3'h7, 8'h13, 8'he1, 8'he8}};
    mspi_master #(.BAUD_W(12)) dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_stb),
        .I_RD(rd_stb), .O_RDATA(rdata), .I_GIE(gie), .I_TXC_ACK(ack), .O_IRQ(irq),
        .O_SCK(sck), .O_SCK_OE(sck_oe), .O_MOSI(mosi), .O_MOSI_OE(mosi_oe),
        .I_MISO(miso), .O_MISO_OWN(miso_own));
    spi_slave_model slave (
        .i_clk(clk), .i_rst_n(rst_n), .i_sck(sck), .i_mosi(mosi), .i_cpol(cpol),
        .i_cpha(cpha), .i_lsb(lsb), .i_reply(reply), .o_miso(miso), .o_rx_byte(rx_byte),
        .o_frames(frames));
    // 10 MHz system clock
    initial clk = 1'b0;
    always #50 clk = ~clk;
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    // Lets the edge's updates land before anything is looked at
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : reg_wr
    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    task automatic poll_rx();
        st = 8'h00;
        for (int k = 0; k < 100 && st[RXC_BIT] !== 1'b1; k++) reg_rd(ADDR_STATUS, st);
    endtask : poll_rx
    task automatic wait_frames(input logic [7:0] n);
        for (int k = 0; k < 400 && frames !== n; k++) tick(1);
        chk("frames", frames, n);
    endtask : wait_frames
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, wr_stb, rd_stb, gie, ack, cpol, cpha, lsb} = '0;
        {addr, wdata, reply, st} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(ADDR_STATUS, st);
        chk("status_rst", st, 8'h20);
        reg_rd(ADDR_CTRL, st);
        chk("ctrl_rst", st, CTRL_RESET);
        reg_rd(ADDR_MODE, st);
        chk("mode_rst", st, MODE_RESET);
        reg_rd(3'h7, st);
        chk("unmapped", st, 8'h00);
        chk("oe_rst", mosi_oe, 1'b0);
        reg_wr(ADDR_BAUD_L, 8'h03);
        reg_wr(ADDR_BAUD_H, 8'h00);
        reg_wr(ADDR_CTRL, 8'hf8);
        foreach (rows[i]) begin
            {lsb, cpha, cpol} <= rows[i].fmt;
            reply <= rows[i].reply;
            reg_wr(ADDR_MODE, {MODE_MSPI, 3'h0, rows[i].fmt});
            reg_rd(ADDR_MODE, st);
            chk("mode", st, {MODE_MSPI, 3'h0, rows[i].fmt});
            tick(40);
            chk("sck_idle", sck, rows[i].fmt[0]);
            reg_wr(ADDR_DATA, rows[i].tx);
            poll_rx();
            chk("status", st, 8'he0);
            chk("irq_masked", irq, 8'h00);
            chk("rx_slave", rx_byte, rows[i].tx);
            reg_rd(ADDR_DATA, st);
            chk("rx_master", st, rows[i].exp_rd);
            reg_rd(ADDR_STATUS, st);
            chk("rxc_clear", st, 8'h60);
            reg_wr(ADDR_STATUS, 8'h40);
            reg_rd(ADDR_STATUS, st);
            chk("txc_clear", st, 8'h20);
        end
        // Back-to-back bytes with nothing read in between
        @(posedge clk) gie <= 1'b1;
        tick(1);
        chk("irq_empty", irq, 8'h01);
        reg_wr(ADDR_DATA, 8'h55);
        reg_wr(ADDR_DATA, 8'haa);
        reg_rd(ADDR_STATUS, st);
        chk("full", st, 8'h00);
        wait_frames(8'd10);
        chk("rx_slave", rx_byte, 8'haa);
        reg_rd(ADDR_STATUS, st);
        chk("status", st, 8'he0);
        chk("irq_all", irq, 8'h07);
        reg_rd(ADDR_DATA, st);
        chk("keep_old", st, 8'he9);
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        tick(1);
        chk("irq_ack", irq, 8'h01);
        // Receiver switched off with a byte waiting
        reg_wr(ADDR_DATA, 8'h3c);
        wait_frames(8'd11);
        tick(2);
        reg_wr(ADDR_CTRL, 8'h08);
        reg_rd(ADDR_STATUS, st);
        chk("flush", st, 8'h60);
        chk("miso_own", miso_own, 1'b0);
        // Transmitter switched off in mid-frame
        reg_wr(ADDR_DATA, 8'h99);
        reg_wr(ADDR_CTRL, 8'h00);
        tick(1);
        chk("oe_pending", mosi_oe, 1'b1);
        wait_frames(8'd12);
        tick(4);
        chk("oe_off", mosi_oe, 1'b0);
        chk("rx_slave", rx_byte, 8'h99);
        // Receiver alone must not clock anything
        reg_wr(ADDR_CTRL, 8'h10);
        reg_wr(ADDR_DATA, 8'h42);
        tick(150);
        chk("frames", frames, 8'd12);
        chk("sck_still", sck, 1'b1);
        chk("miso_own", miso_own, 1'b1);
        for (int m = 0; m < 4; m++) begin
            reg_wr(ADDR_MODE, {m[1:0], 6'h0});
            reg_rd(ADDR_MODE, st);
            chk("mode", st, {m[1:0], 6'h0});
            chk("sck_oe", sck_oe, m == 3);
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
